// *** logic/mdc_regs.sv ***
// Control register bank of the three-phase motor driver
// Functional notes
// RULE1 - Code 011b in lock field unlocks registers
// RULE2 - Code 110b locks, later writes discarded
// RULE3 - Lock field stays writable while locked
// RULE4 - Other lock codes keep current state
// RULE5 - Bit5 selects serial output drive, reset 1
// RULE6 - Bits4-3 select slew rate
// RULE7 - Bits2-1 select PWM input scheme
// RULE8 - Writing 1 to bit0 clears faults
// RULE9 - Clear command bit self clears, reads 0
// RULE10 - Protection bit4 selects full duty frequency
// RULE11 - Protection bit3 selects overvoltage threshold
// RULE12 - Protection bit2 enables overvoltage, reset 1
// RULE13 - Protection bit0 reports thermal warning on fault pin
// RULE14 - Keyed fields change only with whole write
// RULE15 - Reset unlocked; discarded writes change nothing
`timescale 1ns/100ps
`include "mdc_defines.svh"
module mdc_regs
  import mdc_pkg::*;
(
  input  wire logic       clock,                // Logic clock, 50 MHz
  input  wire logic       rst,                  // Asynchronous reset, active high
  input  wire mdc_req_s   req,                  // Register access from the serial framer
  output logic     [7:0]  rdata,                // Read data, registered
  output logic            addr_valid,           // Address maps to this bank
  output logic            locked,               // Lock state
  output logic            fault_clear_command,  // One-cycle clear of latched faults
  output mdc_cfg_s        cfg,                  // Decoded configuration
  input  wire logic       thermal_warning,      // Over-temperature warning from sensor
  input  wire logic       other_fault,          // Other fault sources for the fault pin
  output logic            fault_pin_n,          // Active-low fault pin drive
  input  wire logic       sdo_data,             // Serial data bit to send
  input  wire logic       sdo_active,           // Serial output currently shifting
  output logic            sdo_out,              // Serial data output level
  output logic            sdo_oe                // Serial data output enable
);
  logic [7:0] lock_reg;    // Lock control register
  logic [7:0] lock_next;
  logic [7:0] drive_reg;   // Drive interface configuration
  logic [7:0] drive_next;
  logic [7:0] prot_reg;    // Protection configuration
  logic [7:0] prot_next;
  logic [7:0] rdata_reg;   // Read data holding register
  logic [7:0] rdata_next;
  logic       clr_reg;     // Clear pulse register
  logic       clr_next;
  logic       fault_reg;   // Fault pin state, high means fault
  logic       fault_next;
  logic       key_wr;      // Write to the lock register

  // Lock write strobe, always accepted
  // RULE3 - lock field always writable
  assign key_wr = req.wr && (req.addr == `MDC_OFS_LOCK);

  // Lock state machine
  mdc_lock_fsm u_lock (
    .clock  (clock),
    .rst    (rst),
    .key_wr (key_wr),
    .key    (req.wdata[2:0]),
    .locked (locked)
  );

  // Register next values
  always_comb begin
    lock_next  = lock_reg;
    drive_next = drive_reg;
    prot_next  = prot_reg;
    clr_next   = 1'b0;
    // RULE14 - whole keyed write only
    if (key_wr) begin
      lock_next = req.wdata & `MDC_LOCK_MASK;
    end
    // RULE15 - discard writes while locked
    if (req.wr && !locked && req.addr == `MDC_OFS_DRIVE) begin
      // RULE9 - clear bit never stored
      drive_next = req.wdata & `MDC_DRIVE_MASK;
      // RULE8 - one writes clear faults
      clr_next   = req.wdata[`MDC_BIT_CLR];
    end
    if (req.wr && !locked && req.addr == `MDC_OFS_PROT) begin
      prot_next = req.wdata & `MDC_PROT_MASK;
    end
  end

  // Register storage
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lock_reg  <= `MDC_RST_LOCK;
      drive_reg <= `MDC_RST_DRIVE;
      prot_reg  <= `MDC_RST_PROT;
      clr_reg   <= 1'b0;
    end else begin
      lock_reg  <= lock_next;
      drive_reg <= drive_next;
      prot_reg  <= prot_next;
      clr_reg   <= clr_next;
    end
  end

  // Read mux, unmapped reads zero
  always_comb begin
    rdata_next = rdata_reg;
    addr_valid = 1'b0;
    case (req.addr)
      `MDC_OFS_LOCK: begin
        addr_valid = 1'b1;
      end
      `MDC_OFS_DRIVE: begin
        addr_valid = 1'b1;
      end
      `MDC_OFS_PROT: begin
        addr_valid = 1'b1;
      end
      default: begin
        addr_valid = 1'b0;
      end
    endcase
    if (req.rd) begin
      case (req.addr)
        `MDC_OFS_LOCK:  rdata_next = lock_reg;
        `MDC_OFS_DRIVE: rdata_next = drive_reg;
        `MDC_OFS_PROT:  rdata_next = prot_reg;
        default:        rdata_next = 8'h00;
      endcase
    end
  end

  // Fault pin combines sources
  always_comb begin
    // RULE13 - thermal warning gated
    fault_next = other_fault |
                 (thermal_warning & prot_reg[`MDC_BIT_THERMAL_WARNING_REPORT_ENABLE]);
  end

  // Read data and fault pin registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata_reg <= 8'h00;
      fault_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      fault_reg <= fault_next;
    end
  end

  assign rdata               = rdata_reg;
  assign fault_clear_command = clr_reg;
  assign fault_pin_n         = ~fault_reg;

  // Configuration decode
  // RULE5 - serial drive select
  assign cfg.serial_out_drive_select       = drive_reg[`MDC_BIT_SDO];
  // RULE6 - slew rate field
  assign cfg.slew = mdc_slew_e'(drive_reg[`MDC_BIT_SLEW_HI:`MDC_BIT_SLEW_LO]);
  // RULE7 - PWM scheme field
  assign cfg.pwm_mode = mdc_pwm_e'(drive_reg[`MDC_BIT_PWM_HI:`MDC_BIT_PWM_LO]);
  // RULE10 - full duty frequency
  assign cfg.duty100_40k                   = prot_reg[`MDC_BIT_DUTY100];
  // RULE11 - overvoltage threshold
  assign cfg.overvoltage_threshold_select  = prot_reg[`MDC_BIT_OVERVOLTAGE_THRESHOLD_SELECT];
  // RULE12 - overvoltage enable
  assign cfg.overvoltage_protect_enable    = prot_reg[`MDC_BIT_OVERVOLTAGE_PROTECT_ENABLE];
  assign cfg.thermal_warning_report_enable = prot_reg[`MDC_BIT_THERMAL_WARNING_REPORT_ENABLE];

  // Serial output driver, open drain drives low only
  // RULE5 - open drain or push pull
  always_comb begin
    sdo_out = sdo_data;
    if (!sdo_active) begin
      sdo_oe = 1'b0;
    end else if (cfg.serial_out_drive_select) begin
      sdo_oe = 1'b1;
    end else begin
      sdo_out = 1'b0;
      sdo_oe  = !sdo_data;
    end
  end

  // RULE15 - locked writes discarded
  a_locked_hold: assert property (@(posedge clock) disable iff (rst) // RULE15
    (locked && req.wr && req.addr != `MDC_OFS_LOCK) |=> ($stable(drive_reg) && $stable(prot_reg)))
    else $error("register changed while locked");
  // RULE8 - clear pulse on write
  a_clear_pulse: assert property (@(posedge clock) disable iff (rst) // RULE8
    (req.wr && !locked && req.addr == `MDC_OFS_DRIVE && req.wdata[`MDC_BIT_CLR])
    |=> fault_clear_command ##1 (!fault_clear_command || $past(clr_next)))
    else $error("clear pulse wrong");
  // RULE15 - no clear while locked
  a_locked_noclr: assert property (@(posedge clock) disable iff (rst) // RULE15
    (locked && req.wr) |=> !fault_clear_command)
    else $error("clear issued while locked");
  // RULE9 - clear bit reads zero
  a_clear_reads0: assert property (@(posedge clock) disable iff (rst) // RULE9
    drive_reg[`MDC_BIT_CLR] == 1'b0)
    else $error("clear bit stored");
  // RULE3 - lock field write lands
  a_lock_field: assert property (@(posedge clock) disable iff (rst) // RULE3
    key_wr |=> lock_reg[2:0] == $past(req.wdata[2:0]))
    else $error("lock field not written");
  // RULE13 - thermal report gating
  a_otw_gate: assert property (@(posedge clock) disable iff (rst) // RULE13
    (!other_fault && thermal_warning && !prot_reg[`MDC_BIT_THERMAL_WARNING_REPORT_ENABLE]) |=> fault_pin_n)
    else $error("thermal warning reported while disabled");
  // RULE6 - unlocked drive write lands
  a_drive_write: assert property (@(posedge clock) disable iff (rst) // RULE6
    (req.wr && !locked && req.addr == `MDC_OFS_DRIVE)
    |=> drive_reg == ($past(req.wdata) & `MDC_DRIVE_MASK))
    else $error("drive write lost");
  // RULE12 - unlocked write takes effect
  a_prot_write: assert property (@(posedge clock) disable iff (rst) // RULE12
    (req.wr && !locked && req.addr == `MDC_OFS_PROT)
    |=> prot_reg == ($past(req.wdata) & `MDC_PROT_MASK))
    else $error("protection write lost");
  // RULE5 - idle line left undriven
  a_sdo_release: assert property (@(posedge clock) disable iff (rst) // RULE5
    !sdo_active |-> !sdo_oe)
    else $error("serial output driven while idle");
  // RULE5 - open drain pulls low only
  a_sdo_open_drain: assert property (@(posedge clock) disable iff (rst) // RULE5
    (sdo_oe && !cfg.serial_out_drive_select) |-> !sdo_out)
    else $error("open drain output driven high");
endmodule : mdc_regs

// *** logic/mdc_defines.svh ***
// Offsets, field positions, reset values and codes of the motor driver control registers
`ifndef MDC_DEFINES_SVH
`define MDC_DEFINES_SVH
`define MDC_OFS_LOCK      6'h03
`define MDC_OFS_DRIVE     6'h04
`define MDC_OFS_PROT      6'h05
`define MDC_RST_LOCK      8'h00
`define MDC_RST_DRIVE     8'h60
`define MDC_RST_PROT      8'h46
`define MDC_LOCK_CODE_UNL 3'h3
`define MDC_LOCK_CODE_LCK 3'h6
`define MDC_LOCK_MASK     8'h07
`define MDC_DRIVE_MASK    8'hfe
`define MDC_PROT_MASK     8'h7f
`define MDC_BIT_SDO       5
`define MDC_BIT_SLEW_HI   4
`define MDC_BIT_SLEW_LO   3
`define MDC_BIT_PWM_HI    2
`define MDC_BIT_PWM_LO    1
`define MDC_BIT_CLR       0
`define MDC_BIT_DUTY100   4
`define MDC_BIT_OVERVOLTAGE_THRESHOLD_SELECT   3
`define MDC_BIT_OVERVOLTAGE_PROTECT_ENABLE    2
`define MDC_BIT_THERMAL_WARNING_REPORT_ENABLE   0
`endif

// *** logic/mdc_pkg.sv ***
// Types shared by the motor driver control register bank
package mdc_pkg;
  // Slew rate selection
  typedef enum logic [1:0] {
    MDC_SLEW_25  = 2'h0,
    MDC_SLEW_50  = 2'h1,
    MDC_SLEW_125 = 2'h2,
    MDC_SLEW_200 = 2'h3
  } mdc_slew_e;
  // PWM input scheme
  typedef enum logic [1:0] {
    MDC_PWM_6X    = 2'h0,
    MDC_PWM_6X_CL = 2'h1,
    MDC_PWM_3X    = 2'h2,
    MDC_PWM_3X_CL = 2'h3
  } mdc_pwm_e;
  // Lock state machine, one-hot
  typedef enum logic [1:0] {
    MDC_ST_UNLOCKED = 2'b01,
    MDC_ST_LOCKED   = 2'b10
  } mdc_lock_e;
  // Register access request, write or read
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } mdc_req_s;
  // Configuration seen by the driver core
  typedef struct packed {
    logic      serial_out_drive_select;
    mdc_slew_e slew;
    mdc_pwm_e  pwm_mode;
    logic      duty100_40k;
    logic      overvoltage_threshold_select;
    logic      overvoltage_protect_enable;
    logic      thermal_warning_report_enable;
  } mdc_cfg_s;
endpackage : mdc_pkg

// *** logic/mdc_lock_fsm.sv ***
// Lock state machine for the keyed write protection
`timescale 1ns/100ps
`include "mdc_defines.svh"
module mdc_lock_fsm
  import mdc_pkg::*;
(
  input  wire logic       clock,   // Logic clock
  input  wire logic       rst,     // Asynchronous reset
  input  wire logic       key_wr,  // Keyed write to the lock field
  input  wire logic [2:0] key,     // Value written
  output logic            locked   // High while writes are discarded
);
  mdc_lock_e state_reg;   // Current state
  mdc_lock_e state_next;  // Next state

  // Next state from key code
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      MDC_ST_UNLOCKED: begin
        // RULE2 - lock code locks
        if (key_wr && key == `MDC_LOCK_CODE_LCK) begin
          state_next = MDC_ST_LOCKED;
        end
      end
      MDC_ST_LOCKED: begin
        // RULE1 - unlock code unlocks
        if (key_wr && key == `MDC_LOCK_CODE_UNL) begin
          state_next = MDC_ST_UNLOCKED;
        end
      end
      default: begin
        state_next = MDC_ST_UNLOCKED;
      end
    endcase
  end

  // State register, unlocked at reset
  // RULE15 - reset to unlocked
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg <= MDC_ST_UNLOCKED;
    end else begin
      state_reg <= state_next;
    end
  end

  assign locked = (state_reg == MDC_ST_LOCKED);

  // RULE4 - other codes keep state
  a_other_keep: assert property (@(posedge clock) disable iff (rst) // RULE4
    (key_wr && key != `MDC_LOCK_CODE_UNL && key != `MDC_LOCK_CODE_LCK) |=> $stable(locked))
    else $error("lock state changed on neutral code");
  // RULE2 - lock code locks
  a_lock_sets: assert property (@(posedge clock) disable iff (rst) // RULE2
    (key_wr && key == `MDC_LOCK_CODE_LCK) |=> locked)
    else $error("lock code did not lock");
  // RULE1 - unlock code unlocks
  a_unlock_clears: assert property (@(posedge clock) disable iff (rst) // RULE1
    (key_wr && key == `MDC_LOCK_CODE_UNL) |=> !locked)
    else $error("unlock code did not unlock");
endmodule : mdc_lock_fsm

// *** verification/mdc_host_model.sv ***
// Host-side model of the serial data line with its pull-up
`timescale 1ns/100ps
module mdc_host_model (
  input  wire logic sdo_out,  // Level driven by the device
  input  wire logic sdo_oe,   // Device drive enable
  output logic      sdo_line  // Line level seen by the host
);
  // Pull-up takes the line high whenever the device lets go
  assign sdo_line = sdo_oe ? sdo_out : 1'b1;
endmodule : mdc_host_model

// *** verification/test_motor_driver_control_regs.sv ***
// Self-checking bench for the control register bank
`timescale 1ns/100ps
module test_motor_driver_control_regs
  import mdc_pkg::*;
;
  logic      clock = 1'b0;  // Logic clock
  logic      rst = 1'b1;    // Reset
  mdc_req_s  req;           // Register access
  mdc_cfg_s  cfg;           // Decoded configuration
  logic [7:0] rdata;        // Read data
  logic      addr_valid, locked, fault_clear_command, fault_pin_n;
  logic      thermal_warning, other_fault, sdo_data, sdo_active;
  logic      sdo_out, sdo_oe, sdo_line, clr_seen;
  int        mismatches, tests_run, cycles;
  logic [1:0] i2;           // Field code under test

  mdc_regs uut (.clock(clock), .rst(rst), .req(req), .rdata(rdata), .addr_valid(addr_valid),
    .locked(locked), .fault_clear_command(fault_clear_command), .cfg(cfg),
    .thermal_warning(thermal_warning), .other_fault(other_fault), .fault_pin_n(fault_pin_n),
    .sdo_data(sdo_data), .sdo_active(sdo_active), .sdo_out(sdo_out), .sdo_oe(sdo_oe));
  mdc_host_model host (.sdo_out(sdo_out), .sdo_oe(sdo_oe), .sdo_line(sdo_line));

  // Clock of 20 ns period
  always #10 clock = ~clock;

  // Cut a hung run short
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      conclude();
    end
  end

  // Compare and count
  task check(input logic [15:0] s, input logic [15:0] e);
    tests_run++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : check

  // One write cycle; records the clear pulse in the following cycle
  task wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clock);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock);
    req.wr <= 1'b0;
    @(negedge clock);
    clr_seen = fault_clear_command;
  endtask : wr

  // One read cycle, data checked the cycle after
  task rd(input logic [5:0] a, input logic [7:0] e);
    @(posedge clock);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clock);
    check({15'h0, addr_valid}, {15'h0, (a >= 6'h03 && a <= 6'h05)});
    @(posedge clock);
    req.rd <= 1'b0;
    @(negedge clock);
    check({8'h0, rdata}, {8'h0, e});
  endtask : rd

  // Fault sources, pin checked after its register stage
  task flt(input logic tw, input logic of, input logic e);
    @(posedge clock);
    thermal_warning <= tw;
    other_fault <= of;
    repeat (2) @(posedge clock);
    @(negedge clock);
    check({15'h0, fault_pin_n}, {15'h0, e});
  endtask : flt

  // Serial output drive and resolved line
  task sdo(input logic act, input logic dat, input logic eo, input logic el);
    @(posedge clock);
    sdo_active <= act;
    sdo_data <= dat;
    @(negedge clock);
    check({14'h0, sdo_oe, sdo_line}, {14'h0, eo, el});
  endtask : sdo

  // Every lock code other than the two keys keeps the state
  task codes(input logic e);
    for (int c = 0; c < 8; c++) begin
      if (c != 3 && c != 6) begin
        wr(6'h03, 8'(c));
        check({15'h0, locked}, {15'h0, e});
        rd(6'h03, 8'(c));
      end
    end
  endtask : codes

  // Verdict and end of run
  task conclude;
    $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : conclude

  // Main sequence
  initial begin
    req = '0;
    {thermal_warning, other_fault, sdo_data, sdo_active} = 4'h0;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    rd(6'h03, 8'h00);
    rd(6'h04, 8'h60);
    rd(6'h05, 8'h46);
    rd(6'h3f, 8'h00);
    check({15'h0, locked}, 16'h0000);
    check({7'h0, cfg}, 16'h0102);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      i2 = 2'(i);
      wr(6'h04, {3'b011, i2, i2, 1'b0});
      rd(6'h04, {3'b011, i2, i2, 1'b0});
      check({7'h0, cfg}, {7'h0, 1'b1, i2, i2, 4'h2});
      check({14'h0, cfg.pwm_mode}, {14'h0, i2});
      check({15'h0, clr_seen}, 16'h0000);
    end
    $display("test fields done");
    wr(6'h04, 8'h01);
    check({15'h0, clr_seen}, 16'h0001);
    @(negedge clock);
    check({15'h0, fault_clear_command}, 16'h0000);
    rd(6'h04, 8'h00);
    sdo(1'b1, 1'b1, 1'b0, 1'b1);
    sdo(1'b1, 1'b0, 1'b1, 1'b0);
    wr(6'h04, 8'h20);
    sdo(1'b1, 1'b1, 1'b1, 1'b1);
    sdo(1'b0, 1'b0, 1'b0, 1'b1);
    $display("test drive done");
    wr(6'h05, 8'hff);
    rd(6'h05, 8'h7f);
    check({12'h0, cfg[3:0]}, 16'h000f);
    wr(6'h05, 8'h42);
    check({12'h0, cfg[3:0]}, 16'h0000);
    flt(1'b1, 1'b0, 1'b1);
    wr(6'h05, 8'h01);
    flt(1'b1, 1'b0, 1'b0);
    flt(1'b0, 1'b1, 1'b0);
    flt(1'b0, 1'b0, 1'b1);
    wr(6'h05, 8'h00);
    $display("test protection done");
    codes(1'b0);
    wr(6'h03, 8'h06);
    check({15'h0, locked}, 16'h0001);
    wr(6'h04, 8'h79);
    check({15'h0, clr_seen}, 16'h0000);
    rd(6'h04, 8'h20);
    wr(6'h05, 8'h1d);
    rd(6'h05, 8'h00);
    codes(1'b1);
    wr(6'h03, 8'h03);
    check({15'h0, locked}, 16'h0000);
    wr(6'h04, 8'h61);
    check({15'h0, clr_seen}, 16'h0001);
    rd(6'h04, 8'h60);
    $display("test lock done");
    wr(6'h03, 8'h06);
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    check({15'h0, locked}, 16'h0000);
    rd(6'h05, 8'h46);
    wr(6'h05, 8'h47);
    rd(6'h05, 8'h47);
    $display("test second reset done");
    conclude();
  end
endmodule : test_motor_driver_control_regs
